// ### design/tmr_pkg.sv
// constants shared by the quad counter/timer set: register map, fields, codes
// assumes a 32-bit avalon-mm slave with byte addresses, one register per word
package tmr_pkg;

  localparam int ADDR_W = 6;

  // register byte offsets
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_MODE = 6'h04;
  localparam logic [5:0] OFF_CNT0 = 6'h08;
  localparam logic [5:0] OFF_CNT1 = 6'h0c;
  localparam logic [5:0] OFF_CNT2 = 6'h10;
  localparam logic [5:0] OFF_CNT3 = 6'h14;
  localparam logic [5:0] OFF_RLD2 = 6'h18;
  localparam logic [5:0] OFF_RLD3 = 6'h1c;
  localparam logic [5:0] OFF_CFG23 = 6'h20;
  localparam logic [5:0] OFF_STATUS = 6'h24;
  localparam logic [5:0] OFF_MASK = 6'h28;

  // control register fields
  localparam int CTRL_SCALE_LSB = 0;
  localparam int CTRL_SYS0 = 2;
  localparam int CTRL_SYS1 = 3;
  localparam int CTRL_RUN0 = 4;
  localparam int CTRL_RUN1 = 5;

  // mode register: one nibble per timer, then gate polarities
  localparam int MODE_ONE_LSB = 4;
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_COUNTER = 2;
  localparam int MODE_GATE = 3;
  localparam int MODE_POL0 = 8;
  localparam int MODE_POL1 = 9;

  // timer two/three config: one byte per timer
  localparam int CFG_T3_LSB = 8;
  localparam int CFG_SPLIT = 0;
  localparam int CFG_CLK_LSB = 1;
  localparam int CFG_RUN_LO = 3;
  localparam int CFG_RUN_HI = 4;

  // status / mask bit positions
  localparam int ST_OVF0 = 0;
  localparam int ST_OVF1 = 1;
  localparam int ST_T2LO = 2;
  localparam int ST_T2HI = 3;
  localparam int ST_T3LO = 4;
  localparam int ST_T3HI = 5;
  localparam int NUM_EVT = 6;

  // reset values
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // prescaler dividers
  localparam int DIV_SYS12 = 12;
  localparam int DIV_SYS4 = 4;
  localparam int DIV_SYS48 = 48;
  localparam int DIV_EXT8 = 8;

  // prescale source field codes
  localparam logic [1:0] SCA_SYS12 = 2'h0;
  localparam logic [1:0] SCA_SYS4 = 2'h1;
  localparam logic [1:0] SCA_SYS48 = 2'h2;

  // timer two/three clock codes (code 3 stops the clock)
  localparam logic [1:0] CLK23_SYS = 2'h0;
  localparam logic [1:0] CLK23_DIV12 = 2'h1;
  localparam logic [1:0] CLK23_EXT8 = 2'h2;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } t01_mode_e;

endpackage

// ### design/fall_detect.sv
// two-stage synchroniser with falling-edge pulse
// assumes din changes no faster than every two clock cycles
`timescale 1ns/1ps
module fall_detect (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic din, // asynchronous level
  output logic fall // one-cycle pulse per high-to-low
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // all stages follow the pin, so a level held through reset is no edge
      meta_r <= din;
      sync_r <= din;
      prev_r <= din;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign fall = prev_r & ~sync_r;
endmodule

// ### design/quad_counter_timer_set.sv
// four 16-bit counter/timers behind an avalon-mm slave with interrupt
// assumes one system clock, inputs synchronous except pins run through fall_detect
// What this block does
// - four 16-bit timers: two classic, two auto-reload; timer one holds while timer zero is split.
// - timers zero/one: 13-bit, 16-bit, 8-bit reload; split mode on zero only.
// - timers two/three: 16-bit reload or two independent 8-bit reload timers.
// - timers zero/one pick system clock or shared prescaled clock per select bit.
// - timers two/three clock from sysclk, sysclk/12, or external clock/8.
// - counter mode increments on each falling edge of the event pin.
// - events up to a quarter of system clock rate are counted.
// - timers measure intervals, count events and raise periodic interrupts.
// - prescale field: 00 sys/12, 01 sys/4, 10 sys/48, 11 external/8.
// - 13-bit mode uses high byte plus low five bits; wrap sets flag.
// - count only with run set and gate satisfied (split high byte: run one, no gate); run never clears count.
// - 8-bit reload: low counts, overflow sets flag and reloads from high.
`timescale 1ns/1ps
module quad_counter_timer_set (
  input wire logic clk, // 50 MHz system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic [5:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic event_input_zero, // timer zero event pin
  input wire logic event_input_one, // timer one event pin
  input wire logic external_irq_input_zero, // gate input for timer zero
  input wire logic external_irq_input_one, // gate input for timer one
  input wire logic ext_osc_clk, // external oscillator, sampled
  output logic irq // level interrupt
);
  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle per access
  localparam int NUM_EVT_W = tmr_pkg::NUM_EVT;
  logic wait_r;
  logic [31:0] readdata_r;
  logic [31:0] rd_mux;
  logic wr_go;
  logic rd_go;
  logic [15:0] ctrl_r;
  logic [15:0] mode_r;
  logic [15:0] cfg23_r;
  logic [15:0] cnt0_r;
  logic [15:0] cnt1_r;
  logic [15:0] cnt23_r [2];
  logic [15:0] rld23_r [2];
  logic [NUM_EVT_W-1:0] status_r;
  logic [NUM_EVT_W-1:0] mask_r;
  logic [NUM_EVT_W-1:0] evt_set;
  logic irq_r;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  assign wr_go = avs_write & ~wait_r;
  assign rd_go = avs_read & ~wait_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_r <= 1'b1;
    end else if ((avs_read | avs_write) & wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_comb begin
    rd_mux = tmr_pkg::RST_RDATA;
    if (avs_address == tmr_pkg::OFF_CTRL) begin
      rd_mux[15:0] = ctrl_r;
    end else if (avs_address == tmr_pkg::OFF_MODE) begin
      rd_mux[15:0] = mode_r;
    end else if (avs_address == tmr_pkg::OFF_CNT0) begin
      rd_mux[15:0] = cnt0_r;
    end else if (avs_address == tmr_pkg::OFF_CNT1) begin
      rd_mux[15:0] = cnt1_r;
    end else if (avs_address == tmr_pkg::OFF_CNT2) begin
      rd_mux[15:0] = cnt23_r[0];
    end else if (avs_address == tmr_pkg::OFF_CNT3) begin
      rd_mux[15:0] = cnt23_r[1];
    end else if (avs_address == tmr_pkg::OFF_RLD2) begin
      rd_mux[15:0] = rld23_r[0];
    end else if (avs_address == tmr_pkg::OFF_RLD3) begin
      rd_mux[15:0] = rld23_r[1];
    end else if (avs_address == tmr_pkg::OFF_CFG23) begin
      rd_mux[15:0] = cfg23_r;
    end else if (avs_address == tmr_pkg::OFF_STATUS) begin
      rd_mux[NUM_EVT_W-1:0] = status_r;
    end else if (avs_address == tmr_pkg::OFF_MASK) begin
      rd_mux[NUM_EVT_W-1:0] = mask_r;
    end
  end

  // data captured in the wait cycle, stands in the answer cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readdata_r <= tmr_pkg::RST_RDATA;
    end else if (avs_read & wait_r) begin
      readdata_r <= rd_mux;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= tmr_pkg::RST_REG;
      mode_r <= tmr_pkg::RST_REG;
      cfg23_r <= tmr_pkg::RST_REG;
      mask_r <= '0;
    end else if (wr_go) begin
      if (avs_address == tmr_pkg::OFF_CTRL) begin
        ctrl_r <= merge16(ctrl_r, avs_writedata, avs_byteenable);
      end else if (avs_address == tmr_pkg::OFF_MODE) begin
        mode_r <= merge16(mode_r, avs_writedata, avs_byteenable);
      end else if (avs_address == tmr_pkg::OFF_CFG23) begin
        cfg23_r <= merge16(cfg23_r, avs_writedata, avs_byteenable);
      end else if (avs_address == tmr_pkg::OFF_MASK && avs_byteenable[0]) begin
        mask_r <= avs_writedata[NUM_EVT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and prescalers
  logic ev0_fall;
  logic ev1_fall;
  logic ext_fall;
  logic [2:0] ext_cnt_r;
  logic ext8_tick;
  logic [5:0] presc_cnt_r;
  logic [5:0] presc_top;
  logic presc_tick;
  logic [3:0] div12_cnt_r;
  logic div12_tick;

  fall_detect u_ev0 (.clk(clk), .sys_rst(sys_rst), .din(event_input_zero), .fall(ev0_fall));
  fall_detect u_ev1 (.clk(clk), .sys_rst(sys_rst), .din(event_input_one), .fall(ev1_fall));
  fall_detect u_ext (.clk(clk), .sys_rst(sys_rst), .din(ext_osc_clk), .fall(ext_fall));

  // external clock over eight, synchronised to the system clock
  assign ext8_tick = ext_fall && (ext_cnt_r == 3'(tmr_pkg::DIV_EXT8 - 1));
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_cnt_r <= '0;
    end else if (ext_fall) begin
      ext_cnt_r <= ext_cnt_r + 3'h1;
    end
  end

  always_comb begin
    if (ctrl_r[tmr_pkg::CTRL_SCALE_LSB +: 2] == tmr_pkg::SCA_SYS4) begin
      presc_top = 6'(tmr_pkg::DIV_SYS4 - 1);
    end else if (ctrl_r[tmr_pkg::CTRL_SCALE_LSB +: 2] == tmr_pkg::SCA_SYS48) begin
      presc_top = 6'(tmr_pkg::DIV_SYS48 - 1);
    end else begin
      presc_top = 6'(tmr_pkg::DIV_SYS12 - 1);
    end
  end

  // a shrinking divisor may leave the count past its top: >= wraps it at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      presc_cnt_r <= '0;
    end else if (presc_cnt_r >= presc_top) begin
      presc_cnt_r <= '0;
    end else begin
      presc_cnt_r <= presc_cnt_r + 6'h01;
    end
  end

  assign presc_tick = (ctrl_r[tmr_pkg::CTRL_SCALE_LSB +: 2] == 2'h3) ? ext8_tick :
                      (presc_cnt_r >= presc_top);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div12_cnt_r <= '0;
    end else if (div12_cnt_r == 4'(tmr_pkg::DIV_SYS12 - 1)) begin
      div12_cnt_r <= '0;
    end else begin
      div12_cnt_r <= div12_cnt_r + 4'h1;
    end
  end
  assign div12_tick = (div12_cnt_r == 4'(tmr_pkg::DIV_SYS12 - 1));

  ////////////////////////////////////////////////////////////////////////////
  // timers zero and one
  tmr_pkg::t01_mode_e mode0;
  tmr_pkg::t01_mode_e mode1;
  logic tclk0;
  logic tclk1;
  logic en0;
  logic en1;
  logic [12:0] c13_0;
  logic [12:0] c13_1;
  logic [15:0] cnt0_nxt;
  logic [15:0] cnt1_nxt;
  logic ovf0;
  logic ovf1;

  assign mode0 = tmr_pkg::t01_mode_e'(mode_r[tmr_pkg::MODE_SEL_LSB +: 2]);
  assign mode1 = tmr_pkg::t01_mode_e'(mode_r[tmr_pkg::MODE_ONE_LSB + tmr_pkg::MODE_SEL_LSB +: 2]);

  // timer clock per select bit, counter mode replaces it with the pin
  assign tclk0 = ctrl_r[tmr_pkg::CTRL_SYS0] | presc_tick;
  assign tclk1 = ctrl_r[tmr_pkg::CTRL_SYS1] | presc_tick;

  assign en0 = ctrl_r[tmr_pkg::CTRL_RUN0] && (!mode_r[tmr_pkg::MODE_GATE] ||
               external_irq_input_zero == mode_r[tmr_pkg::MODE_POL0]) &&
               (mode_r[tmr_pkg::MODE_COUNTER] ? ev0_fall : tclk0);
  assign en1 = ctrl_r[tmr_pkg::CTRL_RUN1] &&
               (!mode_r[tmr_pkg::MODE_ONE_LSB + tmr_pkg::MODE_GATE] ||
               external_irq_input_one == mode_r[tmr_pkg::MODE_POL1]) &&
               (mode_r[tmr_pkg::MODE_ONE_LSB + tmr_pkg::MODE_COUNTER] ? ev1_fall : tclk1);

  assign c13_0 = {cnt0_r[15:8], cnt0_r[4:0]} + 13'h0001;
  assign c13_1 = {cnt1_r[15:8], cnt1_r[4:0]} + 13'h0001;

  always_comb begin
    cnt0_nxt = cnt0_r;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    case (mode0)
      tmr_pkg::MODE_13BIT: begin
        if (en0) begin
          cnt0_nxt = {c13_0[12:5], cnt0_r[7:5], c13_0[4:0]};
          ovf0 = (c13_0 == 13'h0000);
        end
      end
      tmr_pkg::MODE_16BIT: begin
        if (en0) begin
          cnt0_nxt = cnt0_r + 16'h0001;
          ovf0 = (cnt0_r == 16'hffff);
        end
      end
      tmr_pkg::MODE_RELOAD8: begin
        if (en0) begin
          cnt0_nxt[7:0] = (cnt0_r[7:0] == 8'hff) ? cnt0_r[15:8] : cnt0_r[7:0] + 8'h01;
          ovf0 = (cnt0_r[7:0] == 8'hff);
        end
      end
      default: begin
        // split: low byte keeps timer zero controls, high byte borrows run one
        if (en0) begin
          cnt0_nxt[7:0] = cnt0_r[7:0] + 8'h01;
          ovf0 = (cnt0_r[7:0] == 8'hff);
        end
        if (ctrl_r[tmr_pkg::CTRL_RUN1] && tclk0) begin
          cnt0_nxt[15:8] = cnt0_r[15:8] + 8'h01;
          ovf1 = (cnt0_r[15:8] == 8'hff);
        end
      end
    endcase
    cnt1_nxt = cnt1_r;
    // timer one holds its count while timer zero is split or it is in split itself
    if (en1 && mode0 != tmr_pkg::MODE_SPLIT) begin
      case (mode1)
        tmr_pkg::MODE_13BIT: begin
          cnt1_nxt = {c13_1[12:5], cnt1_r[7:5], c13_1[4:0]};
          ovf1 = (c13_1 == 13'h0000);
        end
        tmr_pkg::MODE_16BIT: begin
          cnt1_nxt = cnt1_r + 16'h0001;
          ovf1 = (cnt1_r == 16'hffff);
        end
        tmr_pkg::MODE_RELOAD8: begin
          cnt1_nxt[7:0] = (cnt1_r[7:0] == 8'hff) ? cnt1_r[15:8] : cnt1_r[7:0] + 8'h01;
          ovf1 = (cnt1_r[7:0] == 8'hff);
        end
        default: begin
          cnt1_nxt = cnt1_r;
        end
      endcase
    end
  end

  // a software write wins over a count in the same cycle; run never clears
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt0_r <= tmr_pkg::RST_REG;
      cnt1_r <= tmr_pkg::RST_REG;
    end else begin
      if (wr_go && avs_address == tmr_pkg::OFF_CNT0) begin
        cnt0_r <= merge16(cnt0_r, avs_writedata, avs_byteenable);
      end else begin
        cnt0_r <= cnt0_nxt;
      end
      if (wr_go && avs_address == tmr_pkg::OFF_CNT1) begin
        cnt1_r <= merge16(cnt1_r, avs_writedata, avs_byteenable);
      end else begin
        cnt1_r <= cnt1_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timers two and three
  logic [1:0] ovf23_lo;
  logic [1:0] ovf23_hi;

  for (genvar i = 0; i < 2; i++) begin : g_t23
    logic [7:0] cfg;
    logic tick;
    logic run_lo;
    logic run_hi;
    logic wr_cnt;
    logic wr_rld;
    assign cfg = cfg23_r[i * tmr_pkg::CFG_T3_LSB +: 8];
    assign tick = (cfg[tmr_pkg::CFG_CLK_LSB +: 2] == tmr_pkg::CLK23_SYS) ||
                  (cfg[tmr_pkg::CFG_CLK_LSB +: 2] == tmr_pkg::CLK23_DIV12 && div12_tick) ||
                  (cfg[tmr_pkg::CFG_CLK_LSB +: 2] == tmr_pkg::CLK23_EXT8 && ext8_tick);
    assign run_lo = cfg[tmr_pkg::CFG_RUN_LO] && tick;
    assign run_hi = cfg[tmr_pkg::CFG_RUN_HI] && tick;
    assign wr_cnt = wr_go && avs_address == (i == 0 ? tmr_pkg::OFF_CNT2 : tmr_pkg::OFF_CNT3);
    assign wr_rld = wr_go && avs_address == (i == 0 ? tmr_pkg::OFF_RLD2 : tmr_pkg::OFF_RLD3);
    assign ovf23_lo[i] = cfg[tmr_pkg::CFG_SPLIT] && run_lo && cnt23_r[i][7:0] == 8'hff;
    assign ovf23_hi[i] = cfg[tmr_pkg::CFG_SPLIT] ? (run_hi && cnt23_r[i][15:8] == 8'hff) :
                         (run_lo && cnt23_r[i] == 16'hffff);

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        rld23_r[i] <= tmr_pkg::RST_REG;
      end else if (wr_rld) begin
        rld23_r[i] <= merge16(rld23_r[i], avs_writedata, avs_byteenable);
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        cnt23_r[i] <= tmr_pkg::RST_REG;
      end else if (wr_cnt) begin
        cnt23_r[i] <= merge16(cnt23_r[i], avs_writedata, avs_byteenable);
      end else if (cfg[tmr_pkg::CFG_SPLIT]) begin
        if (run_lo) begin
          cnt23_r[i][7:0] <= ovf23_lo[i] ? rld23_r[i][7:0] : cnt23_r[i][7:0] + 8'h01;
        end
        if (run_hi) begin
          cnt23_r[i][15:8] <= ovf23_hi[i] ? rld23_r[i][15:8] : cnt23_r[i][15:8] + 8'h01;
        end
      end else if (run_lo) begin
        cnt23_r[i] <= ovf23_hi[i] ? rld23_r[i] : cnt23_r[i] + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky overflow flags, cleared by reading; only bits seen by the read clear
  logic [NUM_EVT_W-1:0] status_clr;

  assign evt_set[tmr_pkg::ST_OVF0] = ovf0;
  assign evt_set[tmr_pkg::ST_OVF1] = ovf1;
  assign evt_set[tmr_pkg::ST_T2LO] = ovf23_lo[0];
  assign evt_set[tmr_pkg::ST_T2HI] = ovf23_hi[0];
  assign evt_set[tmr_pkg::ST_T3LO] = ovf23_lo[1];
  assign evt_set[tmr_pkg::ST_T3HI] = ovf23_hi[1];

  assign status_clr = (rd_go && avs_address == tmr_pkg::OFF_STATUS) ?
                      readdata_r[NUM_EVT_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~status_clr) | evt_set;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  assign avs_readdata = readdata_r;
  assign avs_waitrequest = wait_r;
  assign irq = irq_r;
endmodule

// ### dv/tmr_checker.sv
// bus handshake and interrupt assertions for the quad counter/timer set
// assumes it is bound to quad_counter_timer_set and sees one clock domain
`timescale 1ns/1ps
module tmr_checker (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic [5:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic irq // level interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic req;
  logic clr;
  assign req = avs_read | avs_write;
  // only a completed status read or mask write may take irq down
  assign clr = !avs_waitrequest && ((avs_read && avs_address == tmr_pkg::OFF_STATUS) ||
    (avs_write && avs_address == tmr_pkg::OFF_MASK));
  ////////////////////////////////////////////////////////////////////////////////
  property p_wait_answer;
    req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer after one wait");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
  property p_wait_cause;
    $fell(avs_waitrequest) |-> $past(req);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_wait_idle;
    !req |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait low while idle");
  property p_unmapped;
    avs_read && avs_waitrequest && avs_address > tmr_pkg::OFF_MASK |=> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_upper_zero;
    avs_read && avs_waitrequest |=> avs_readdata[31:16] == 16'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_status_width;
    avs_read && avs_waitrequest && avs_address == tmr_pkg::OFF_STATUS
      |=> avs_readdata[31:6] == 26'h0;
  endproperty
  a_status_width: assert property (p_status_width) else $error("stray status bits");
  property p_rdata_hold;
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_irq_fall;
    $fell(irq) |-> $past(clr) || $past(clr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
  c_irq_rise: cover property ($rose(irq));
endmodule
bind quad_counter_timer_set tmr_checker tmr_checker_inst (.clk(clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

// ### dv/tmr_event_source.sv
// model of the external event pins and oscillator feeding the timer set
// assumes the bench calls pulse between edges of clk only
`timescale 1ns/1ps
module tmr_event_source (
  input wire logic clk, // system clock
  output logic event_input_zero, // event pin zero
  output logic event_input_one, // event pin one
  output wire logic ext_osc_clk // external oscillator
);
  logic [1:0] ph = 2'h0;
  initial begin
    event_input_zero = 1'b1;
    event_input_one = 1'b1;
  end
  // quarter of system rate, each level held two cycles
  always @(posedge clk) begin
    ph <= ph + 2'h1;
  end
  assign ext_osc_clk = ph[1];
  // idle high, so no edge is seen outside a pulse
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge clk);
      if (ch == 0) event_input_zero <= 1'b0;
      else event_input_one <= 1'b0;
      repeat (2) @(posedge clk);
      if (ch == 0) event_input_zero <= 1'b1;
      else event_input_one <= 1'b1;
      @(posedge clk);
    end
  endtask
endmodule

// ### dv/quad_counter_timer_set_tb.sv
// self-checking bench for the quad counter/timer set
// assumes the event source model and the bound checker are compiled alongside
`timescale 1ns/1ps
module quad_counter_timer_set_tb;
  logic clk;
  logic sys_rst;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic event_input_zero;
  logic event_input_one;
  logic ext_osc_clk;
  logic external_irq_input_zero;
  logic external_irq_input_one;
  logic irq;
  int failures;
  int cmp_count;
  int dv[5] = '{12, 4, 48, 32, 1};
  quad_counter_timer_set quad_counter_timer_set_inst (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .event_input_zero(event_input_zero),
    .event_input_one(event_input_one), .external_irq_input_zero(external_irq_input_zero),
    .external_irq_input_one(external_irq_input_one), .ext_osc_clk(ext_osc_clk), .irq(irq));
  tmr_event_source tmr_event_source_inst (.clk(clk), .event_input_zero(event_input_zero),
    .event_input_one(event_input_one), .ext_osc_clk(ext_osc_clk));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // request held until waitrequest is sampled low, released after that edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) failures++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 16'h0, q);
    chk(what, q, exp);
  endtask
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask
  // prescaler phase is free, so allow one period of slack
  task automatic meas(input int d, input logic [15:0] st, input string what);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(what, {31'h0, n >= 3 * d && n <= 4 * d + 10}, 32'h1);
    wr(tmr_pkg::OFF_CTRL, 16'h0);
    wr(tmr_pkg::OFF_CFG23, 16'h0);
    rd_chk(tmr_pkg::OFF_STATUS, {16'h0, st}, "periodic flag");
    irq_chk(1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic scn_regs();
    for (int a = 0; a <= 40; a += 4) rd_chk(6'(a), 32'h0, "reset value");
    wr(tmr_pkg::OFF_CNT3, 16'ha5c3);
    rd_chk(tmr_pkg::OFF_CNT3, 32'ha5c3, "count three");
    wr(6'h30, 16'hffff);
    rd_chk(6'h30, 32'h0, "unmapped");
    wr(tmr_pkg::OFF_MASK, 16'h003f);
  endtask
  task automatic scn_wrap13();
    wr(tmr_pkg::OFF_MODE, 16'h0004);
    wr(tmr_pkg::OFF_CNT0, 16'hfffe);
    wr(tmr_pkg::OFF_CTRL, 16'h0010);
    tmr_event_source_inst.pulse(0, 2);
    rd_chk(tmr_pkg::OFF_CNT0, 32'h00e0, "wrap of short count");
    chk("irq raised", {31'h0, irq}, 32'h1);
    rd_chk(tmr_pkg::OFF_STATUS, 32'h1, "flag zero");
    rd_chk(tmr_pkg::OFF_STATUS, 32'h0, "flag cleared");
    irq_chk(1'b0);
  endtask
  task automatic scn_wrap16();
    wr(tmr_pkg::OFF_MODE, 16'h0005);
    wr(tmr_pkg::OFF_CNT0, 16'hffff);
    tmr_event_source_inst.pulse(0, 1);
    rd_chk(tmr_pkg::OFF_CNT0, 32'h0, "full wrap");
    irq_chk(1'b1);
    wr(tmr_pkg::OFF_MASK, 16'h0);
    irq_chk(1'b0);
    rd_chk(tmr_pkg::OFF_STATUS, 32'h1, "sticky flag");
    wr(tmr_pkg::OFF_MASK, 16'h003f);
  endtask
  task automatic scn_reload();
    wr(tmr_pkg::OFF_MODE, 16'h02e0);
    wr(tmr_pkg::OFF_CTRL, 16'h0020);
    wr(tmr_pkg::OFF_CNT1, 16'h80fe);
    tmr_event_source_inst.pulse(1, 1);
    rd_chk(tmr_pkg::OFF_CNT1, 32'h80fe, "gate one closed");
    external_irq_input_one <= 1'b1;
    tmr_event_source_inst.pulse(1, 3);
    rd_chk(tmr_pkg::OFF_CNT1, 32'h8081, "reloaded byte");
    rd_chk(tmr_pkg::OFF_STATUS, 32'h2, "flag one");
  endtask
  task automatic scn_gate();
    wr(tmr_pkg::OFF_MODE, 16'h010d);
    wr(tmr_pkg::OFF_CNT0, 16'h0);
    wr(tmr_pkg::OFF_CTRL, 16'h0010);
    tmr_event_source_inst.pulse(0, 3);
    rd_chk(tmr_pkg::OFF_CNT0, 32'h0, "gate closed");
    external_irq_input_zero <= 1'b1;
    tmr_event_source_inst.pulse(0, 2);
    rd_chk(tmr_pkg::OFF_CNT0, 32'h2, "gate open");
    wr(tmr_pkg::OFF_CTRL, 16'h0);
    tmr_event_source_inst.pulse(0, 2);
    wr(tmr_pkg::OFF_CTRL, 16'h0010);
    rd_chk(tmr_pkg::OFF_CNT0, 32'h2, "run kept count");
    wr(tmr_pkg::OFF_CTRL, 16'h0);
    external_irq_input_zero <= 1'b0;
  endtask
  // sysclk runs three counts between the start and stop writes
  task automatic scn_split();
    wr(tmr_pkg::OFF_MODE, 16'h0003);
    wr(tmr_pkg::OFF_CNT0, 16'hff00);
    wr(tmr_pkg::OFF_CTRL, 16'h0024);
    wr(tmr_pkg::OFF_CTRL, 16'h0000);
    rd_chk(tmr_pkg::OFF_CNT0, 32'h0200, "split high byte");
    wr(tmr_pkg::OFF_RLD2, 16'h1020);
    wr(tmr_pkg::OFF_CNT2, 16'hffff);
    wr(tmr_pkg::OFF_CFG23, 16'h0019);
    wr(tmr_pkg::OFF_CFG23, 16'h0000);
    rd_chk(tmr_pkg::OFF_CNT2, 32'h1222, "split reload");
    rd_chk(tmr_pkg::OFF_STATUS, 32'h000e, "split flags");
  endtask
  task automatic scn_clocks();
    wr(tmr_pkg::OFF_MODE, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      wr(tmr_pkg::OFF_CNT0, 16'hfffc);
      wr(tmr_pkg::OFF_CTRL, i < 4 ? 16'h0010 | 16'(i) : 16'h0014);
      meas(dv[i], 16'h0001, "timer zero clock");
    end
    wr(tmr_pkg::OFF_RLD2, 16'hfffc);
    for (int i = 0; i < 3; i++) begin
      wr(tmr_pkg::OFF_CNT2, 16'hfffc);
      wr(tmr_pkg::OFF_CFG23, 16'h0008 | 16'(i << 1));
      meas(i == 0 ? 1 : (i == 1 ? 12 : 32), 16'h0008, "timer two clock");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    sys_rst = 1'b1;
    avs_address = 6'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    external_irq_input_zero = 1'b0;
    external_irq_input_one = 1'b0;
    failures = 0;
    cmp_count = 0;
    repeat (11) @(posedge clk);
    chk("wait in reset", {31'h0, avs_waitrequest}, 32'h1);
    chk("irq in reset", {31'h0, irq}, 32'h0);
    @(posedge clk);
    sys_rst <= 1'b0;
    scn_regs();
    scn_wrap13();
    scn_wrap16();
    scn_reload();
    scn_gate();
    scn_split();
    scn_clocks();
    conclude();
  end
endmodule
